// *** boot_mode_pkg.sv ***
// Package for the boot mode selector: boot mode codes, sequence states and widths.
// Assumes one 100 MHz clock domain; shared by the selector and its bench.
`default_nettype none

package boot_mode_pkg;

   // ----------------------------------------------------------------
   // Boot configuration codes, {upper pin, lower pin}
   // ----------------------------------------------------------------
   localparam logic [1:0] CFG_USER      = 2'h3;
   localparam logic [1:0] CFG_STANDARD  = 2'h2;
   localparam logic [1:0] CFG_SELECTIVE = 2'h1;
   localparam logic [1:0] CFG_RESERVED  = 2'h0;

   // Position of the two configuration pins within the low half of port 0
   localparam int CFG_PIN_LO = 4;
   localparam int CFG_PIN_HI = 5;
   localparam int PORT_LOW_W = 8;

   // Boot code fetch target at address zero
   localparam logic FETCH_USER_FLASH = 1'b0;
   localparam logic FETCH_TEST_FLASH = 1'b1;

   // Loader channel codes
   localparam logic [1:0] CHAN_NONE = 2'h0;
   localparam logic [1:0] CHAN_UART = 2'h1;
   localparam logic [1:0] CHAN_CAN  = 2'h2;

   // Signature width
   localparam int SIG_W = 32;

   // Reset values
   localparam logic [1:0] MODE_RESET = CFG_RESERVED;

   typedef enum logic [7:0] {
      ST_IDLE     = 8'h01,
      ST_USER     = 8'h02,
      ST_SCAN     = 8'h04,
      ST_UART     = 8'h08,
      ST_CAN      = 8'h10,
      ST_SIGCHK   = 8'h20,
      ST_SWRESET  = 8'h40,
      ST_RESERVED = 8'h80
   } boot_state_e;

endpackage : boot_mode_pkg

`default_nettype wire

// *** boot_mode_selector.sv ***
// Boot mode selector: latches the configuration pins at reset release, maps
// code fetches at address zero and launches the chosen loader channel.
// Assumes clk_i is free running; pins and the reset pin arrive asynchronously.
`default_nettype none

module boot_mode_selector
   import boot_mode_pkg::*;
#(
   parameter int DOMINANT_MIN = 3
)
(
   input  wire logic                              clk_i,
   input  wire logic                              reset_i,
   input  wire logic                              external_reset_input_i,
   input  wire logic [boot_mode_pkg::PORT_LOW_W-1:0] config_port_low_half_i,
   input  wire logic                              uart_receive_line_i,
   input  wire logic                              can_receive_line_i,
   input  wire logic [boot_mode_pkg::SIG_W-1:0]   sig_word0_i,
   input  wire logic [boot_mode_pkg::SIG_W-1:0]   sig_word1_i,
   input  wire logic [boot_mode_pkg::SIG_W-1:0]   sig_reference_i,
   input  wire logic                              user_key_can_i,
   output logic [1:0]                             boot_mode_o,
   output logic                                   fetch_test_flash_o,
   output logic [1:0]                             loader_channel_o,
   output logic                                   software_reset_o,
   output logic                                   run_user_code_o
);
   import boot_mode_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers, three stages
   // ----------------------------------------------------------------
   logic [2:0] rst_sync_reg, uart_sync_reg, can_sync_reg;
   logic [2:0] rst_sync_next, uart_sync_next, can_sync_next;
   logic [1:0] pin_sync_reg [3];
   logic [1:0] pin_sync_next [3];
   logic       rst_level_reg, uart_level_reg, can_level_reg;
   logic       rst_level_next, uart_level_next, can_level_next;

   always_comb
   begin
      rst_sync_next  = {rst_sync_reg[1:0], external_reset_input_i};
      uart_sync_next = {uart_sync_reg[1:0], uart_receive_line_i};
      can_sync_next  = {can_sync_reg[1:0], can_receive_line_i};
      pin_sync_next[0] = {config_port_low_half_i[CFG_PIN_HI],
                          config_port_low_half_i[CFG_PIN_LO]};
      pin_sync_next[1] = pin_sync_reg[0];
      pin_sync_next[2] = pin_sync_reg[1];
      // Level changes only once stages two and three agree
      rst_level_next  = (rst_sync_reg[1] == rst_sync_reg[2]) ? rst_sync_reg[2] : rst_level_reg;
      uart_level_next = (uart_sync_reg[1] == uart_sync_reg[2]) ? uart_sync_reg[2]
                                                                : uart_level_reg;
      can_level_next  = (can_sync_reg[1] == can_sync_reg[2]) ? can_sync_reg[2] : can_level_reg;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rst_sync_reg   <= 3'h0;
         uart_sync_reg  <= 3'h7;
         can_sync_reg   <= 3'h7;
         pin_sync_reg[0] <= 2'h0;
         pin_sync_reg[1] <= 2'h0;
         pin_sync_reg[2] <= 2'h0;
         rst_level_reg  <= 1'b0;
         uart_level_reg <= 1'b1;
         can_level_reg  <= 1'b1;
      end
      else
      begin
         rst_sync_reg   <= rst_sync_next;
         uart_sync_reg  <= uart_sync_next;
         can_sync_reg   <= can_sync_next;
         pin_sync_reg   <= pin_sync_next;
         rst_level_reg  <= rst_level_next;
         uart_level_reg <= uart_level_next;
         can_level_reg  <= can_level_next;
      end
   end

   // Reset pin rises: the one and only capture point
   logic rst_rise;
   assign rst_rise = rst_level_next & ~rst_level_reg;

   // ----------------------------------------------------------------
   // Boot sequence
   // ----------------------------------------------------------------
   boot_state_e state_reg, state_next;
   logic [1:0]  mode_reg, mode_next;
   logic        fetch_reg, fetch_next;
   logic [1:0]  chan_reg, chan_next;
   logic        swrst_reg, swrst_next;
   logic        user_reg, user_next;
   logic [7:0]  dom_cnt_reg, dom_cnt_next;

   always_comb
   begin
      state_next   = state_reg;
      mode_next    = mode_reg;
      fetch_next   = fetch_reg;
      chan_next    = chan_reg;
      swrst_next   = 1'b0;
      user_next    = user_reg;
      dom_cnt_next = dom_cnt_reg;
      // Capture first: the rise is seen while the old level is still low
      if (rst_rise)
      begin
         mode_next = pin_sync_reg[2];
         unique case (pin_sync_reg[2])
            CFG_USER:
            begin
               state_next = ST_USER;
               fetch_next = FETCH_USER_FLASH;
               user_next  = 1'b1;
            end
            CFG_STANDARD:
            begin
               state_next = ST_SCAN;
               fetch_next = FETCH_TEST_FLASH;
            end
            CFG_SELECTIVE:
            begin
               state_next = ST_SIGCHK;
               fetch_next = FETCH_TEST_FLASH;
            end
            default:
            begin
               state_next = ST_RESERVED;
               fetch_next = FETCH_USER_FLASH;
            end
         endcase
      end
      else if (!rst_level_reg)
      begin
         // Device held in reset by the pin: nothing runs
         state_next   = ST_IDLE;
         user_next    = 1'b0;
         chan_next    = CHAN_NONE;
         dom_cnt_next = 8'h00;
      end
      else
      begin
         // Mode and mapping only change at a capture point
         unique case (state_reg)
            ST_SCAN:
            begin
               // Both lines watched in the same cycle; UART wins a tie
               if (!uart_level_reg)
               begin
                  state_next = ST_UART;
                  chan_next  = CHAN_UART;
               end
               else if (!can_level_reg)
               begin
                  if (dom_cnt_reg == 8'(DOMINANT_MIN - 1))
                  begin
                     state_next = ST_CAN;
                     chan_next  = CHAN_CAN;
                  end
                  else
                     dom_cnt_next = dom_cnt_reg + 8'h01;
               end
               else
                  dom_cnt_next = 8'h00;
            end
            ST_SIGCHK:
            begin
               if ((sig_word0_i ^ sig_word1_i) == sig_reference_i)
               begin
                  state_next = ST_SWRESET;
                  swrst_next = 1'b1;
               end
               else
               begin
                  state_next = user_key_can_i ? ST_CAN : ST_UART;
                  chan_next  = user_key_can_i ? CHAN_CAN : CHAN_UART;
               end
            end
            ST_SWRESET:
            begin
               state_next = ST_USER;
               user_next  = 1'b1;
            end
            ST_IDLE, ST_USER, ST_UART, ST_CAN, ST_RESERVED:
               state_next = state_reg;
            default:
               state_next = ST_RESERVED;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_reg   <= ST_IDLE;
         mode_reg    <= MODE_RESET;
         fetch_reg   <= FETCH_USER_FLASH;
         chan_reg    <= CHAN_NONE;
         swrst_reg   <= 1'b0;
         user_reg    <= 1'b0;
         dom_cnt_reg <= 8'h00;
      end
      else
      begin
         state_reg   <= state_next;
         mode_reg    <= mode_next;
         fetch_reg   <= fetch_next;
         chan_reg    <= chan_next;
         swrst_reg   <= swrst_next;
         user_reg    <= user_next;
         dom_cnt_reg <= dom_cnt_next;
      end
   end

   assign boot_mode_o        = mode_reg;
   assign fetch_test_flash_o = fetch_reg;
   assign loader_channel_o   = chan_reg;
   assign software_reset_o   = swrst_reg;
   assign run_user_code_o    = user_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_sig_match;
      state_reg == ST_SIGCHK && (sig_word0_i ^ sig_word1_i) == sig_reference_i;
   endsequence

   property p_capture;
      @(posedge clk_i) disable iff (reset_i)
      rst_rise |=> mode_reg == $past(pin_sync_reg[2]);
   endproperty
   a_capture: assert property (p_capture) else $error("mode not captured");

   property p_user_map;
      @(posedge clk_i) disable iff (reset_i)
      mode_reg == CFG_USER |-> !fetch_test_flash_o;
   endproperty
   a_user_map: assert property (p_user_map) else $error("user mode fetch map");

   property p_boot_map;
      @(posedge clk_i) disable iff (reset_i)
      (mode_reg == CFG_STANDARD || mode_reg == CFG_SELECTIVE) |-> fetch_test_flash_o;
   endproperty
   a_boot_map: assert property (p_boot_map) else $error("boot fetch map");

   property p_sel_entry;
      @(posedge clk_i) disable iff (reset_i)
      rst_rise && pin_sync_reg[2] == CFG_SELECTIVE |=> state_reg == ST_SIGCHK;
   endproperty
   a_sel_entry: assert property (p_sel_entry) else $error("selective not entered");

   property p_swreset;
      @(posedge clk_i) disable iff (reset_i)
      s_sig_match and (!rst_rise && rst_level_reg) |=> software_reset_o ##1 run_user_code_o;
   endproperty
   a_swreset: assert property (p_swreset) else $error("no software reset");

   property p_uart;
      @(posedge clk_i) disable iff (reset_i)
      state_reg == ST_SCAN && !uart_level_reg && !rst_rise && rst_level_reg
      |=> loader_channel_o == CHAN_UART;
   endproperty
   a_uart: assert property (p_uart) else $error("uart loader not launched");

   property p_reserved;
      @(posedge clk_i) disable iff (reset_i)
      mode_reg == CFG_RESERVED |-> !run_user_code_o && loader_channel_o == CHAN_NONE;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode booted");

   property p_hold;
      @(posedge clk_i) disable iff (reset_i)
      !rst_rise |=> $stable(mode_reg) && $stable(fetch_test_flash_o);
   endproperty
   a_hold: assert property (p_hold) else $error("mode changed without reset");

endmodule : boot_mode_selector

`default_nettype wire

// *** boot_mode_selector_test.sv ***
// Bench for the boot mode selector: every expected change of the output vector goes in a queue.
// Assumes boot_mode_pkg and host_model are compiled first.
`default_nettype none

`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("wrong value %s expected %h seen %h", nm, e, g); \
      end \
   end

module boot_mode_selector_test;
   import boot_mode_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  clk_i   = 1'b0;
   logic                  reset_i = 1'b1;
   logic                  pin     = 1'b0;
   logic [PORT_LOW_W-1:0] cfg     = '0;
   logic [SIG_W-1:0]      w0      = '0;
   logic [SIG_W-1:0]      w1      = '0;
   logic [SIG_W-1:0]      ref_sig = '0;
   logic [SIG_W-1:0]      a;
   logic [SIG_W-1:0]      b;
   logic                  key     = 1'b0;
   wire logic             uart_l;
   wire logic             can_l;
   logic [1:0]            mode_o;
   logic [1:0]            chan_o;
   logic                  fetch_o;
   logic                  swr_o;
   logic                  user_o;
   logic [6:0]            exp_v   = '0;
   logic [6:0]            prev_v  = '0;
   logic [6:0]            exp_t;
   logic [6:0]            sel;
   logic [6:0]            q[$];
   int                    n_fail  = 0;
   int                    checked = 0;
   int                    cycles  = 0;
   integer                seed    = 32'hE80DA529;
   wire logic [6:0]       out_v   = {mode_o, fetch_o, chan_o, swr_o, user_o};

   always #5 clk_i = ~clk_i;

   boot_mode_selector #(.DOMINANT_MIN(3)) uut
   (
      .clk_i                  (clk_i),
      .reset_i                (reset_i),
      .external_reset_input_i (pin),
      .config_port_low_half_i (cfg),
      .uart_receive_line_i    (uart_l),
      .can_receive_line_i     (can_l),
      .sig_word0_i            (w0),
      .sig_word1_i            (w1),
      .sig_reference_i        (ref_sig),
      .user_key_can_i         (key),
      .boot_mode_o            (mode_o),
      .fetch_test_flash_o     (fetch_o),
      .loader_channel_o       (chan_o),
      .software_reset_o       (swr_o),
      .run_user_code_o        (user_o)
   );

   host_model host
   (
      .clk_i       (clk_i),
      .uart_line_o (uart_l),
      .can_line_o  (can_l)
   );

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic conclude;
      $display("counts: checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   // Repeated vectors are dropped: the monitor only sees changes
   task automatic note(input logic [6:0] v);
      if (v !== exp_v)
         q.push_back(v);
      exp_v = v;
   endtask : note

   // Extra idle cycles catch late or spurious output changes
   task automatic settle(input string nm);
      int i;
      i = 0;
      while (q.size() != 0 && i < 60)
      begin
         @(posedge clk_i);
         i++;
      end
      repeat (8) @(posedge clk_i);
      if (q.size() != 0)
      begin
         `CHK("queue left", 0, q.size())
         q.delete();
      end
      if (nm != "")
         $display("test %s done", nm);
   endtask : settle

   task automatic boot(input logic [1:0] c, input logic [6:0] v);
      logic [PORT_LOW_W-1:0] r;
      r = PORT_LOW_W'($random(seed));
      r[CFG_PIN_HI] = c[1];
      r[CFG_PIN_LO] = c[0];
      @(posedge clk_i);
      pin <= 1'b0;
      note({exp_v[6:4], 4'h0});
      settle("");
      cfg <= r;
      @(posedge clk_i);
      pin <= 1'b1;
      note(v);
   endtask : boot

   // ---------------------------------------------------------------
   // Monitor and hang guard
   // ---------------------------------------------------------------
   // Falling edge: outputs have settled and notes from the rising edge are in
   always @(negedge clk_i)
   begin
      cycles++;
      if (!reset_i && out_v !== prev_v)
      begin
         if (q.size() == 0)
            `CHK("unexpected change", prev_v, out_v)
         else
         begin
            exp_t = q.pop_front();
            `CHK("outputs", exp_t, out_v)
         end
      end
      prev_v <= out_v;
      if (cycles == 5000)
      begin
         n_fail++;
         conclude();
      end
   end

   initial
   begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      boot(CFG_RESERVED, 7'h00);
      settle("reserved after reset");
      boot(CFG_USER, {CFG_USER, FETCH_USER_FLASH, CHAN_NONE, 2'b01});
      // Flip the pins only once the capture is long past
      repeat (6) @(posedge clk_i);
      cfg <= ~cfg;
      settle("user mode");
      boot(CFG_RESERVED, 7'h00);
      settle("reserved after user");
      sel = {CFG_STANDARD, FETCH_TEST_FLASH, CHAN_NONE, 2'b00};
      boot(CFG_STANDARD, sel);
      note(sel | {3'h0, CHAN_UART, 2'b00});
      host.pulse(1'b1, 1'b0, 4);
      settle("standard uart");
      boot(CFG_STANDARD, sel);
      host.pulse(1'b0, 1'b1, 2);
      settle("short dominant ignored");
      note(sel | {3'h0, CHAN_CAN, 2'b00});
      host.pulse(1'b0, 1'b1, 6);
      settle("standard can");
      boot(CFG_STANDARD, sel);
      note(sel | {3'h0, CHAN_UART, 2'b00});
      host.pulse(1'b1, 1'b1, 6);
      settle("both lines low");
      sel = {CFG_SELECTIVE, FETCH_TEST_FLASH, CHAN_NONE, 2'b00};
      for (int k = 0; k < 3; k++)
      begin
         a = $random(seed);
         b = $random(seed);
         w0 <= a;
         w1 <= b;
         ref_sig <= (k == 0) ? (a ^ b) : (a ^ b ^ 32'h0000_0001);
         key <= (k == 2);
         boot(CFG_SELECTIVE, sel);
         if (k == 0)
         begin
            note(sel | 7'h02);
            note(sel | 7'h01);
         end
         else
            note(sel | ((k == 1) ? {3'h0, CHAN_UART, 2'b00} : {3'h0, CHAN_CAN, 2'b00}));
         settle("selective");
      end
      conclude();
   end

endmodule : boot_mode_selector_test

`default_nettype wire

// *** host_model.sv ***
// Host model: the external loader host driving the UART and CAN receive lines.
// Assumes the bench calls its task; both lines rest high between frames.
`default_nettype none

module host_model
(
   input  wire logic clk_i,
   output var logic  uart_line_o,
   output var logic  can_line_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      uart_line_o = 1'b1;
      can_line_o  = 1'b1;
   end

   // ---------------------------------------------------------------
   // Low phase on either line, then back to the idle level
   // ---------------------------------------------------------------
   task automatic pulse(input bit uart, input bit can, input int n);
      @(posedge clk_i);
      if (uart)
         uart_line_o <= 1'b0;
      if (can)
         can_line_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      uart_line_o <= 1'b1;
      can_line_o  <= 1'b1;
   endtask : pulse

endmodule : host_model

`default_nettype wire
